// ---- halfbridge_spi_control_status.sv ----
// serial control and diagnostic logic of a triple half-bridge driver
// assumes synchronised analog comparator flags at the pins and a master
// that leaves three core cycles after select falls before clocking
`timescale 1ns/1ns
module halfbridge_spi_control_status
  import halfbridge_pkg::*;
#(
  parameter int UL_DELAY_CYCLES = UNDERLOAD_DELAY_CYC
)
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              standby_inhibit_input_in,
  input  wire logic              select_low_input_in,
  input  wire logic              serial_clk_in,
  input  wire logic              serial_in_pin_in,
  input  wire logic [NUM_SW-1:0] overcurrent_in,
  input  wire logic [NUM_SW-1:0] underload_in,
  input  wire logic [NUM_SW-1:0] gate_sense_in,
  input  wire logic              temp_warn_in,
  input  wire logic              temp_cool_in,
  input  wire logic              temp_shutdown_in,
  input  wire logic              supply_over_in,
  input  wire logic              supply_under_in,
  output logic [NUM_SW-1:0]      switch_gate_out,
  output logic                   serial_out_out,
  output logic                   serial_out_oe_out
);

  localparam int UL_CNT_W = $clog2(UL_DELAY_CYCLES + 1);
  localparam logic [OC_CNT_W-1:0] OC_LAST = OC_CNT_W'(OVERCURRENT_DELAY_CYC - 1);
  localparam logic [OC_CNT_W-1:0] OC_FULL = OC_CNT_W'(OVERCURRENT_DELAY_CYC);
  localparam logic [DEAD_W-1:0]   DEAD_DONE = DEAD_W'(LOW_ON_DELAY_CYC);

  sense_type             raw_in;
  sense_type             sense_s1;
  sense_type             sense;
  logic                  select_q;
  wire logic             sys_rst;
  wire logic             csn_rise;
  wire logic             clr_evt;
  wire logic [WORD_W-1:0] rx_word;
  wire logic [NUM_SW-1:0] rx_sw;
  command_type           cmd;
  command_type           next_cmd;
  logic [OC_CNT_W-1:0]   oc_cnt [NUM_SW];
  logic [NUM_SW-1:0]     oc_hit;
  logic [NUM_SW-1:0]     trip;
  logic [UL_CNT_W-1:0]   ul_cnt;
  wire logic             ul_running;
  wire logic             ul_hit;
  logic                  ovl_flag;
  logic                  unl_flag;
  logic                  sup_flag;
  logic                  temp_flag;
  wire logic             all_off;
  wire logic [NUM_SW-1:0] want;
  logic [NUM_SW-1:0]     next_gate;
  logic [DEAD_W-1:0]     dead_cnt [NUM_LEG];
  logic [NUM_LEG-1:0]    low_ok;
  status_type            status_now;
  status_type            tx_snap;

  // ==========================================================
  // pin synchronisers
  // every pin except the clocks, reset and serial data in passes two flops; the first stage feeds only the second
  assign raw_in = '{oc: overcurrent_in, ul: underload_in, gate: gate_sense_in,
                    temp_warn: temp_warn_in, temp_cool: temp_cool_in,
                    temp_shut: temp_shutdown_in, vs_over: supply_over_in,
                    vs_under: supply_under_in,
                    inhibit_n: standby_inhibit_input_in,
                    select_n: select_low_input_in};

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      sense_s1 <= SENSE_RESET;
      sense    <= SENSE_RESET;
    end
    else
    begin
      sense_s1 <= raw_in;
      sense    <= sense_s1;
    end
  end

  // third select stage for the rising edge
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      select_q <= 1'b1;
    else
      select_q <= sense.select_n;
  end

  // power or inhibit reset
  // inhibit acts as a full reset of everything past the synchronisers except select_q
  assign sys_rst  = !reset_n_in || !sense.inhibit_n;
  assign csn_rise = sense.select_n && !select_q;

  // ==========================================================
  // serial link, on the master's clock
  // rx_word is read only after select has settled high, when the serial
  // clock stands still, so the synchronised select qualifies it
  serial_link_shifter link_shifter
  (
    .link_clk_in         (serial_clk_in),
    .select_low_input_in (select_low_input_in),
    .serial_in_pin_in    (serial_in_pin_in),
    .tx_word_in          (tx_snap),
    .rx_word_out         (rx_word),
    .serial_out_out      (serial_out_out)
  );

  // ==========================================================
  // command register
  // unused bits dropped
  assign rx_sw    = rx_word[CMD_SW_LSB +: NUM_SW];
  assign next_cmd = '{overvoltage_cutoff_en: rx_word[CMD_OVERVOLTAGE_CUTOFF_BIT], ocl_en: rx_word[CMD_OCL_BIT],
                      sw: rx_sw};
  assign clr_evt  = csn_rise && rx_word[CMD_CLR_BIT];

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      cmd <= CMD_RESET;
    else if (csn_rise)
      cmd <= next_cmd;
  end

  // ==========================================================
  // overcurrent delay, one counter per switch
  // count the overcurrent delay
  generate
    for (genvar i = 0; i < NUM_SW; i++)
    begin : g_oc
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst || !sense.oc[i] || !switch_gate_out[i])
          oc_cnt[i] <= '0;
        else if (oc_cnt[i] != OC_FULL)
          oc_cnt[i] <= oc_cnt[i] + OC_CNT_W'(1);
      end
      assign oc_hit[i] = (oc_cnt[i] == OC_LAST) && sense.oc[i] && switch_gate_out[i];
    end
  endgenerate

  // lockout only when enabled
  // a trip holds its switch off until the next command; a new trip wins
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      trip <= '0;
    else
      trip <= (trip & ~{NUM_SW{csn_rise}}) | (oc_hit & {NUM_SW{cmd.ocl_en}});
  end

  // ==========================================================
  // shared underload dead time
  // restart on select rising
  assign ul_running = (ul_cnt != '0);

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      ul_cnt <= '0;
    else if (csn_rise)
      ul_cnt <= UL_CNT_W'(UL_DELAY_CYCLES);
    else if (ul_running)
      ul_cnt <= ul_cnt - UL_CNT_W'(1);
  end

  // mask while running
  // open load only means something on a conducting switch
  assign ul_hit = |(sense.ul & switch_gate_out) && !ul_running;

  // ==========================================================
  // latched status flags, set wins over every clear
  // held until cleared
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
    begin
      ovl_flag  <= 1'b0;
      unl_flag  <= 1'b0;
      sup_flag  <= 1'b0;
      temp_flag <= 1'b0;
    end
    else
    begin
      ovl_flag  <= |oc_hit || (ovl_flag && !clr_evt);
      unl_flag  <= ul_hit || (unl_flag && !clr_evt);
      sup_flag  <= sense.vs_over || sense.vs_under || (sup_flag && !clr_evt);
      temp_flag <= sense.temp_warn || (temp_flag && !clr_evt && !sense.temp_cool);
    end
  end

  // ==========================================================
  // switch enables
  // undervoltage off
  assign all_off = sense.temp_shut || sense.vs_under || (cmd.overvoltage_cutoff_en && sense.vs_over);
  assign want    = cmd.sw & ~trip & ~{NUM_SW{all_off}};

  // per leg: even index low side, odd index high side
  generate
    for (genvar l = 0; l < NUM_LEG; l++)
    begin : g_leg
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst || switch_gate_out[2*l+1])
          dead_cnt[l] <= '0;
        else if (!low_ok[l])
          dead_cnt[l] <= dead_cnt[l] + DEAD_W'(1);
      end
      assign low_ok[l] = (dead_cnt[l] == DEAD_DONE);
      // both commanded on: high side wins, low side held off
      assign next_gate[2*l]   = want[2*l] && low_ok[l] && !want[2*l+1];
      assign next_gate[2*l+1] = want[2*l+1] && !switch_gate_out[2*l];
    end
  endgenerate

  // gate drive register
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      switch_gate_out <= '0;
    else
      switch_gate_out <= next_gate;
  end

  // ==========================================================
  // status word and serial output enable
  // gate sense bits
  assign status_now = '{supply_fault: sup_flag, underload: unl_flag, overload: ovl_flag,
                        spare: 6'h00, switch_on: sense.gate, temp_warn: temp_flag};

  // frozen during frame
  // the snapshot only follows while deselected, so the link domain sees a
  // stable word; the master's three cycle wait covers the select sync
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      tx_snap <= STS_RESET;
    else if (sense.select_n)
      tx_snap <= status_now;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst)
      serial_out_oe_out <= 1'b0;
    else
      serial_out_oe_out <= !sense.select_n;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking

  default disable iff (sys_rst);

  sequence s_trip_then_off;
    trip[0] ##1 !switch_gate_out[0];
  endsequence

  sequence s_ul_hold;
    ul_running [*8];
  endsequence

  AST_OC_TRIP_OFF: assert property (oc_hit[0] && cmd.ocl_en |=> s_trip_then_off)
    else $error("overcurrent trip did not turn switch off");

  AST_OC_LIMIT_ONLY: assert property ($rose(trip[0]) |->
      $past(cmd.ocl_en) && $past(oc_cnt[0]) == OC_LAST)
    else $error("trip without lockout or before delay");

  AST_LOW_AFTER_HIGH: assert property ($rose(switch_gate_out[0]) |->
      $past(dead_cnt[0]) == DEAD_DONE && !switch_gate_out[1])
    else $error("low side on too early");

  AST_UL_TIMER: assert property (csn_rise |=> s_ul_hold)
    else $error("underload timer not started");

  AST_UL_MASK: assert property ($rose(unl_flag) |-> $past(!ul_running))
    else $error("underload latched during dead time");

  AST_UV_OFF: assert property (sense.vs_under |=> switch_gate_out == '0)
    else $error("switch on during undervoltage");

  AST_OVERVOLTAGE_CUTOFF_OFF: assert property (cmd.overvoltage_cutoff_en && sense.vs_over |=>
      switch_gate_out == '0)
    else $error("switch on during overvoltage lockout");

  AST_APPLY: assert property (csn_rise |=> cmd.sw == $past(rx_sw))
    else $error("command not applied on select rising");

  AST_CLEAR: assert property (clr_evt && oc_hit == '0 |=> !ovl_flag)
    else $error("status not cleared by command");

  AST_TEMP_CLEAR: assert property (sense.temp_cool && !sense.temp_warn |=>
      !temp_flag)
    else $error("temperature warning not cleared");

  AST_OE_RELEASE: assert property ($rose(sense.select_n) |=> !serial_out_oe_out)
    else $error("serial output still driven after select rose");

endmodule

// ---- halfbridge_pkg.sv ----
// constants, word layouts and timing counts of the half-bridge serial control block
// assumes a 20 MHz core clock; the serial clock is a separate domain
package halfbridge_pkg;

  // ==========================================================
  // word sizes
  localparam int WORD_W = 16;
  localparam int NUM_SW = 6;
  localparam int NUM_LEG = 3;

  // ==========================================================
  // command word bit positions
  localparam int CMD_CLR_BIT = 0;
  localparam int CMD_SW_LSB = 1;
  localparam int CMD_OCL_BIT = 13;
  localparam int CMD_OVERVOLTAGE_CUTOFF_BIT = 15;

  // ==========================================================
  // timing, in their own units and in core cycles
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int OVERCURRENT_DELAY_US = 25;
  localparam int UNDERLOAD_DELAY_US = 350;
  localparam int LOW_ON_DELAY_NS = 400;
  localparam int OVERCURRENT_DELAY_CYC = OVERCURRENT_DELAY_US * (CORE_CLK_HZ / 1_000_000);
  localparam int UNDERLOAD_DELAY_CYC = UNDERLOAD_DELAY_US * (CORE_CLK_HZ / 1_000_000);
  localparam int LOW_ON_DELAY_CYC =
    (LOW_ON_DELAY_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OC_CNT_W = $clog2(OVERCURRENT_DELAY_CYC + 1);
  localparam int DEAD_W = $clog2(LOW_ON_DELAY_CYC + 1);

  // ==========================================================
  // applied command, reset value
  typedef struct packed {
    logic              overvoltage_cutoff_en;
    logic              ocl_en;
    logic [NUM_SW-1:0] sw;
  } command_type;

  localparam command_type CMD_RESET = '{overvoltage_cutoff_en: 1'b0, ocl_en: 1'b0, sw: 6'h00};

  // status word layout, msb first
  typedef struct packed {
    logic              supply_fault;
    logic              underload;
    logic              overload;
    logic [5:0]        spare;
    logic [NUM_SW-1:0] switch_on;
    logic              temp_warn;
  } status_type;

  localparam status_type STS_RESET = 16'h0000;

  // synchronised pin inputs
  typedef struct packed {
    logic [NUM_SW-1:0] oc;
    logic [NUM_SW-1:0] ul;
    logic [NUM_SW-1:0] gate;
    logic              temp_warn;
    logic              temp_cool;
    logic              temp_shut;
    logic              vs_over;
    logic              vs_under;
    logic              inhibit_n;
    logic              select_n;
  } sense_type;

  localparam sense_type SENSE_RESET = 25'h0000001;

endpackage

// ---- serial_link_shifter.sv ----
// serial shift logic running on the master's serial clock
// assumes the serial clock stands still while select is high and that
// tx_word_in is held stable by the core for the whole frame
`timescale 1ns/1ns
module serial_link_shifter
  import halfbridge_pkg::*;
(
  input  wire logic              link_clk_in,
  input  wire logic              select_low_input_in,
  input  wire logic              serial_in_pin_in,
  input  wire logic [WORD_W-1:0] tx_word_in,
  output logic [WORD_W-1:0]      rx_word_out,
  output logic                   serial_out_out
);

  logic [WORD_W-1:0] rx_shift;
  logic [4:0]        bit_cnt;
  logic              out_bit;
  logic              out_started;
  wire logic         past_word;
  wire logic         next_bit;

  // ==========================================================
  // receive side
  // shift command in
  // msb first, rising edge
  // data register carries no reset so it survives select rising
  always_ff @(posedge link_clk_in)
  begin
    rx_shift <= {rx_shift[WORD_W-2:0], serial_in_pin_in};
  end

  // bit count, cleared whenever select is high
  always_ff @(posedge link_clk_in or posedge select_low_input_in)
  begin
    if (select_low_input_in)
      bit_cnt <= 5'h00;
    else if (!past_word)
      bit_cnt <= bit_cnt + 5'h01;
  end

  // ==========================================================
  // transmit side
  // status out
  // after sixteen bits the received data passes through for daisy chains
  assign past_word = (bit_cnt == 5'(WORD_W));
  assign next_bit  = past_word ? rx_shift[WORD_W-1] : tx_word_in[4'hf - bit_cnt[3:0]];

  always_ff @(negedge link_clk_in or posedge select_low_input_in)
  begin
    if (select_low_input_in)
    begin
      out_bit     <= 1'b0;
      out_started <= 1'b0;
    end
    else
    begin
      out_bit     <= next_bit;
      out_started <= 1'b1;
    end
  end

  // msb stands from select falling until the first falling clock edge
  assign serial_out_out = out_started ? out_bit : tx_word_in[WORD_W-1];
  assign rx_word_out    = rx_shift;

endmodule

// ---- spi_master_model.sv ----
// serial bus master model that programs the half-bridge block
// assumes mode 0 framing and a device that drives data out while selected
`timescale 1ns/1ns
module spi_master_model
(
  output logic      select_low_input_out,
  output logic      serial_clk_out,
  output logic      serial_in_pin_out,
  input  wire logic serial_out_in
);
  // ==========================================================
  // link clock half period, 12 ns clock
  localparam int HALF_NS = 6;

  // idle: select high, clock still low
  initial
  begin
    select_low_input_out = 1'b1;
    serial_clk_out = 1'b0;
    serial_in_pin_out = 1'b0;
  end

  // one frame of nbits bits; lead_ns stretches the gap before the first clock
  // frames longer than one word exercise the daisy chain pass-through
  task automatic transfer(input logic [31:0] cmd, input int nbits, input int lead_ns,
                          output logic [31:0] sts);
    sts = '0;
    // select falls, then at least three core cycles
    select_low_input_out = 1'b0;
    #(lead_ns);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      // msb first, set after falling, taken on rising
      serial_in_pin_out = cmd[i];
      #(HALF_NS);
      serial_clk_out = 1'b1;
      sts[i] = serial_out_in;
      #(HALF_NS);
      serial_clk_out = 1'b0;
    end
    #(HALF_NS);
    select_low_input_out = 1'b1;
    // released data line shows the inverse, never a stale bit
    serial_in_pin_out = ~cmd[0];
    // at least four core cycles before the next select fall
    #(250);
  endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the half-bridge serial control block
// assumes the master model is compiled first; gate sense follows gate drive
`timescale 1ns/1ns
module testbench;
  import halfbridge_pkg::*;
  // ==========================================================
  // shortened underload delay keeps the run short
  localparam int UL_CYC = 40;
  localparam int LIMIT  = 20000;
  logic       core_clk;
  logic       reset_n;
  logic       inhibit_n;
  logic       sel_n;
  logic       sclk;
  logic       sdi;
  logic       sdo;
  logic       sdo_oe;
  logic       t_warn;
  logic       t_cool;
  logic       t_shut;
  logic       v_over;
  logic       v_under;
  logic [5:0] oc;
  logic [5:0] ul;
  logic [5:0] gate;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;

  // 20 MHz core clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  halfbridge_spi_control_status #(.UL_DELAY_CYCLES(UL_CYC)) u_halfbridge_spi_control_status (
    .core_clk_in              (core_clk),
    .reset_n_in               (reset_n),
    .standby_inhibit_input_in (inhibit_n),
    .select_low_input_in      (sel_n),
    .serial_clk_in            (sclk),
    .serial_in_pin_in         (sdi),
    .overcurrent_in           (oc),
    .underload_in             (ul),
    .gate_sense_in            (gate),
    .temp_warn_in             (t_warn),
    .temp_cool_in             (t_cool),
    .temp_shutdown_in         (t_shut),
    .supply_over_in           (v_over),
    .supply_under_in          (v_under),
    .switch_gate_out          (gate),
    .serial_out_out           (sdo),
    .serial_out_oe_out        (sdo_oe)
  );

  spi_master_model u_spi_master_model (
    .select_low_input_out (sel_n),
    .serial_clk_out       (sclk),
    .serial_in_pin_out    (sdi),
    .serial_out_in        (sdo)
  );

  // ==========================================================
  // shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // frame ends five core cycles after select rises, command applied by then
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] s);
    logic [31:0] s32;
    u_spi_master_model.transfer({16'h0000, cmd}, 16, 200, s32);
    @(negedge core_clk);
    s = s32[15:0];
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_switches();
    logic [15:0] s;
    // unused command bits set high alongside each switch bit
    for (int k = 0; k < 6; k++)
    begin
      xfer(16'h5f80 | (16'h0002 << k), s);
      wait_cyc(12);
      check("gate map", gate, 6'h01 << k);
    end
    xfer(16'h0004, s);
    wait_cyc(4);
    xfer(16'h0002, s);
    check("leg dead time", gate, 6'h00);
    wait_cyc(12);
    check("lower after delay", gate, 6'h01);
    xfer(16'h0000, s);
    check("status of previous", s, 16'h0002);
    $display("done switches");
  endtask

  // two words in one frame: the first passes through, the second is applied
  task automatic test_chain();
    logic [31:0] s32;
    fork
      u_spi_master_model.transfer(32'h1234_0008, 32, 200, s32);
      begin
        wait_cyc(5);
        check("line driven", sdo_oe, 1'b1);
      end
    join
    @(negedge core_clk);
    check("chain status", s32[31:16], 16'h0000);
    check("chain pass", s32[15:0], 16'h1234);
    wait_cyc(12);
    check("chain command", gate, 6'h04);
    $display("done chain");
  endtask

  task automatic test_overcurrent();
    logic [15:0] s;
    xfer(16'h2002, s);
    wait_cyc(12);
    oc = 6'h01;
    wait_cyc(480);
    check("before delay", gate, 6'h01);
    wait_cyc(40);
    check("tripped", gate, 6'h00);
    xfer(16'h0002, s);
    check("overload flag", s[13], 1'b1);
    wait_cyc(600);
    check("limited only", gate, 6'h01);
    oc = 6'h00;
    xfer(16'h0003, s);
    check("overload kept", s[13], 1'b1);
    xfer(16'h0000, s);
    check("overload cleared", s[13], 1'b0);
    $display("done overcurrent");
  endtask

  task automatic test_underload();
    logic [15:0] s;
    xfer(16'h0002, s);
    ul = 6'h01;
    wait_cyc(20);
    xfer(16'h0002, s);
    check("ul masked", s[14], 1'b0);
    wait_cyc(20);
    xfer(16'h0002, s);
    check("ul timer restarted", s[14], 1'b0);
    wait_cyc(60);
    xfer(16'h0002, s);
    check("ul latched", s[14], 1'b1);
    ul = 6'h00;
    xfer(16'h0001, s);
    xfer(16'h0000, s);
    check("status cleared", s, 16'h0000);
    $display("done underload");
  endtask

  task automatic test_temperature();
    logic [15:0] s;
    xfer(16'h0008, s);
    wait_cyc(12);
    t_warn = 1'b1;
    wait_cyc(4);
    t_warn = 1'b0;
    t_shut = 1'b1;
    wait_cyc(4);
    check("hot stop", gate, 6'h00);
    t_shut = 1'b0;
    wait_cyc(12);
    check("command kept", gate, 6'h04);
    xfer(16'h0008, s);
    check("warn latched", s[0], 1'b1);
    t_cool = 1'b1;
    wait_cyc(4);
    t_cool = 1'b0;
    xfer(16'h0000, s);
    check("warn cleared", s[0], 1'b0);
    $display("done temperature");
  endtask

  task automatic test_supply();
    logic [15:0] s;
    xfer(16'h0020, s);
    wait_cyc(12);
    v_under = 1'b1;
    wait_cyc(4);
    check("under off", gate, 6'h00);
    v_under = 1'b0;
    xfer(16'h0021, s);
    check("under flagged", s[15], 1'b1);
    v_over = 1'b1;
    wait_cyc(12);
    check("no cutoff", gate, 6'h10);
    xfer(16'h8020, s);
    check("over flagged", s[15], 1'b1);
    wait_cyc(4);
    check("cutoff", gate, 6'h00);
    v_over = 1'b0;
    xfer(16'h0001, s);
    $display("done supply");
  endtask

  task automatic test_inhibit();
    logic [15:0] s;
    xfer(16'h0002, s);
    wait_cyc(12);
    t_warn = 1'b1;
    wait_cyc(4);
    t_warn = 1'b0;
    inhibit_n = 1'b0;
    wait_cyc(4);
    check("inhibit off", gate, 6'h00);
    inhibit_n = 1'b1;
    wait_cyc(6);
    xfer(16'h0000, s);
    check("inhibit erased", s, 16'h0000);
    check("line released", sdo_oe, 1'b0);
    $display("done inhibit");
  endtask

  // ==========================================================
  // hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    reset_n = 1'b0;
    inhibit_n = 1'b1;
    oc = 6'h00;
    ul = 6'h00;
    t_warn = 1'b0;
    t_cool = 1'b0;
    t_shut = 1'b0;
    v_over = 1'b0;
    v_under = 1'b0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    wait_cyc(6);
    check("reset gate", gate, 6'h00);
    test_switches();
    test_chain();
    test_overcurrent();
    test_underload();
    test_temperature();
    test_supply();
    test_inhibit();
    give_verdict();
  end
endmodule
